// ---- verilog/lps_pkg.sv ----
package lps_pkg;

  // ****************************************************************
  // Pixel word and lane geometry
  // ****************************************************************
  localparam int PIX_BITS       = 28;
  localparam int LANES          = 4;
  localparam int SLOTS          = 7;
  localparam int FIFO_DEPTH     = 32;
  localparam int CNT_W          = 12;
  localparam int DEPTH_LANE     = 3;
  localparam int DEPTH_LO_BIT   = 21;

  localparam logic [2:0] LAST_SLOT      = 3'h6;
  localparam logic [2:0] CLK_HIGH_SLOTS = 3'h4;
  localparam logic [CNT_W:0] SLOT_STEP  = 13'h0007;

  // ****************************************************************
  // Reset values and cycle counts
  // ****************************************************************
  localparam logic [PIX_BITS-1:0] WORD_RST  = 28'h0000000;
  localparam logic [CNT_W-1:0]    CNT_RST   = 12'h000;
  localparam logic [CNT_W-1:0]    CNT_ONE   = 12'h001;
  localparam logic [CNT_W-1:0]    CNT_MAX   = 12'hFFF;
  localparam logic [3:0]          LOCK_EDGES = 4'h4;

  localparam int CLK_PERIOD_NS = 25;
  localparam int LOSS_TIME_NS  = 2000;
  localparam logic [CNT_W-1:0] LOSS_CYCLES =
    CNT_W'((LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************************************
  // Power and link states
  // ****************************************************************
  typedef enum logic [1:0] {
    LPS_SLEEP,
    LPS_IDLE,
    LPS_LOCKING,
    LPS_ACTIVE
  } lps_state_t;

  // Lane k carries word bits 7k+6 down to 7k, slot 0 first
  function automatic logic lps_slot_bit(input logic [PIX_BITS-1:0] w, input int lane, input logic [2:0] slot);
    int idx;
    idx = lane * SLOTS + 6 - int'(slot);
    return w[idx];
  endfunction

endpackage

// ---- verilog/lps_sync2.sv ----
`timescale 1ns/1ps
module lps_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         sys_rst,
  // Asynchronous in, synchronous out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_q;

  always_comb
  begin
    next_stage1 = d;
    next_q      = stage1;
    if (sys_rst)
    begin
      next_stage1 = '0;
      next_q      = '0;
    end
  end

  always_ff @(posedge clock)
  begin
    stage1 <= next_stage1;
    q      <= next_q;
  end

endmodule

// ---- verilog/lps_fifo.sv ----
`timescale 1ns/1ps
module lps_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 32
) (
  // Clock and synchronous clear
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             do_push;
  logic             do_pop;

  assign in_ready  = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_comb
  begin
    do_push     = in_valid && in_ready;
    do_pop      = out_valid && out_ready;
    next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count;
    if (do_push && !do_pop)
      next_count = count + 1'b1;
    else if (do_pop && !do_push)
      next_count = count - 1'b1;
    if (sys_rst)
    begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end
  end

  always_ff @(posedge clock)
  begin
    wr_ptr <= next_wr_ptr;
    rd_ptr <= next_rd_ptr;
    count  <= next_count;
    if (do_push)
      mem[wr_ptr] <= in_data;
  end

endmodule

// ---- verilog/lps_serializer.sv ----
`timescale 1ns/1ps
// What this block does
// - Each selected pixel clock edge outside sleep captures the 28-bit word; once locked, it is sent on four lanes.
// - Every lane sends exactly seven bit slots per pixel clock period.
// - Forwarded clock runs at pixel rate, high four slots, low three slots.
// - Edge select high latches the word on the pixel clock rising edge.
// - Edge select low latches the word on the falling edge.
// - A stopped pixel clock drops the block into a low power idle state.
// - Sleep input low stops the lock loop and drives all lanes to ground.
// - Swing select picks low or high output amplitude.
// - Depth select high floats lane four and ignores its input bits.
// - Sleep overrides the lane four float, grounding it instead.
// - Unconnected inputs read low by internal pull-downs.
// - Input word holds colour bits, three controls and one spare bit.
module lps_serializer #(
  parameter int FIFO_WORDS = lps_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  // Pixel side pins
  input  wire logic                          pixel_clock,
  input  wire logic [lps_pkg::PIX_BITS-1:0]  pixel_data,
  // Configuration pins
  input  wire logic                          latch_edge_select,
  input  wire logic                          sleep_control_n,
  input  wire logic                          swing_select,
  input  wire logic                          color_depth_select,
  // Serial lanes
  output logic      [lps_pkg::LANES-1:0]     serial_lane_out,
  output logic      [lps_pkg::LANES-1:0]     serial_lane_oe,
  output logic                               forwarded_clock_out,
  output logic                               swing_high,
  // Status
  output logic                               pll_enable,
  output logic                               low_power,
  output logic                               link_locked,
  output logic                               capture_ready,
  output logic                               pixel_overrun
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Clock and data share one synchroniser, so a word stays aligned with its edge
  localparam int SW = lps_pkg::PIX_BITS + 5;

  logic [SW-1:0]                  sync_q;
  logic                           s_pclk;
  logic [lps_pkg::PIX_BITS-1:0]   s_data;
  logic                           s_edge_sel;
  logic                           s_awake;
  logic                           s_swing;
  logic                           s_depth;

  lps_sync2 #(
    .W (SW)
  ) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .d       ({pixel_clock, pixel_data, latch_edge_select, sleep_control_n, swing_select, color_depth_select}),
    .q       (sync_q)
  );

  // Reset clears the stages to low, matching what pulled-down open pins read
  assign {s_pclk, s_data, s_edge_sel, s_awake, s_swing, s_depth} = sync_q;

  // ****************************************************************
  // Edge detection and capture
  // ****************************************************************
  logic                           pclk_prev;
  logic                           rise;
  logic                           fall;
  logic                           latch_evt;
  logic                           push_valid;
  logic [lps_pkg::PIX_BITS-1:0]   push_data;
  logic                           fifo_in_ready;
  logic                           fifo_out_valid;
  logic [lps_pkg::PIX_BITS-1:0]   fifo_out_data;
  logic                           pop;
  logic                           fifo_clear;

  assign rise      = s_pclk && !pclk_prev;
  assign fall      = !s_pclk && pclk_prev;
  assign latch_evt = s_edge_sel ? rise : fall;

  // ****************************************************************
  // Power state and period measurement
  // ****************************************************************
  lps_pkg::lps_state_t            state;
  lps_pkg::lps_state_t            next_state;
  logic [lps_pkg::CNT_W-1:0]      period_cnt;
  logic [lps_pkg::CNT_W-1:0]      next_period_cnt;
  logic [lps_pkg::CNT_W-1:0]      period;
  logic [lps_pkg::CNT_W-1:0]      next_period;
  logic [3:0]                     lock_cnt;
  logic [3:0]                     next_lock_cnt;
  logic                           clk_lost;

  assign clk_lost = (period_cnt >= lps_pkg::LOSS_CYCLES);

  always_comb
  begin
    next_state      = state;
    next_lock_cnt   = lock_cnt;
    next_period     = period;
    next_period_cnt = (period_cnt == lps_pkg::CNT_MAX) ? period_cnt : period_cnt + 1'b1;
    if (latch_evt)
    begin
      next_period     = period_cnt;
      next_period_cnt = lps_pkg::CNT_ONE;
    end
    case (state)
      lps_pkg::LPS_SLEEP:
        if (s_awake)
          next_state = lps_pkg::LPS_IDLE;
      lps_pkg::LPS_IDLE:
        if (latch_evt)
        begin
          next_state    = lps_pkg::LPS_LOCKING;
          next_lock_cnt = 4'h0;
        end
      lps_pkg::LPS_LOCKING:
        if (clk_lost)
          next_state = lps_pkg::LPS_IDLE;
        else if (latch_evt)
        begin
          next_lock_cnt = lock_cnt + 4'h1;
          if (lock_cnt == lps_pkg::LOCK_EDGES - 4'h1)
            next_state = lps_pkg::LPS_ACTIVE;
        end
      lps_pkg::LPS_ACTIVE:
        if (clk_lost)
          next_state = lps_pkg::LPS_IDLE;
      default:
        next_state = lps_pkg::LPS_SLEEP;
    endcase
    // Sleep wins over everything, the lock loop restarts from scratch
    if (!s_awake)
      next_state = lps_pkg::LPS_SLEEP;
    if (sys_rst)
    begin
      next_state      = lps_pkg::LPS_SLEEP;
      next_lock_cnt   = 4'h0;
      next_period     = lps_pkg::CNT_RST;
      next_period_cnt = lps_pkg::CNT_RST;
    end
  end

  always_ff @(posedge clock)
  begin
    state      <= next_state;
    lock_cnt   <= next_lock_cnt;
    period     <= next_period;
    period_cnt <= next_period_cnt;
  end

  // ****************************************************************
  // Pixel buffer
  // ****************************************************************
  // Lane four bits are zeroed in narrow mode so stale levels never reach the buffer
  always_comb
  begin
    push_valid = latch_evt && (state != lps_pkg::LPS_SLEEP);
    push_data  = s_data;
    if (s_depth)
      push_data[lps_pkg::PIX_BITS-1:lps_pkg::DEPTH_LO_BIT] = '0;
  end

  assign pop        = latch_evt && fifo_out_valid;
  assign fifo_clear = sys_rst || (state == lps_pkg::LPS_SLEEP);

  lps_fifo #(
    .WIDTH (lps_pkg::PIX_BITS),
    .DEPTH (FIFO_WORDS)
  ) u_fifo (
    .clock     (clock),
    .sys_rst   (fifo_clear),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  // ****************************************************************
  // Slot timing and output drivers
  // ****************************************************************
  // Slots advance by a 7/period accumulator, so uneven cycle counts spread evenly
  logic [lps_pkg::PIX_BITS-1:0]   word;
  logic [lps_pkg::PIX_BITS-1:0]   next_word;
  logic [2:0]                     slot;
  logic [2:0]                     next_slot;
  logic [lps_pkg::CNT_W-1:0]      acc;
  logic [lps_pkg::CNT_W-1:0]      next_acc;
  logic [lps_pkg::CNT_W:0]        acc_sum;
  logic                           active;
  logic [lps_pkg::LANES-1:0]      next_lane;
  logic [lps_pkg::LANES-1:0]      next_oe;
  logic                           next_fclk;

  assign active = (state == lps_pkg::LPS_ACTIVE);

  always_comb
  begin
    acc_sum   = {1'b0, acc} + lps_pkg::SLOT_STEP;
    next_word = word;
    next_slot = slot;
    next_acc  = acc;
    if (latch_evt)
    begin
      next_word = fifo_out_valid ? fifo_out_data : lps_pkg::WORD_RST;
      next_slot = 3'h0;
      next_acc  = lps_pkg::CNT_RST;
    end
    else if ((acc_sum >= {1'b0, period}) && (slot != lps_pkg::LAST_SLOT))
    begin
      next_slot = slot + 3'h1;
      next_acc  = lps_pkg::CNT_W'(acc_sum - {1'b0, period});
    end
    else
      next_acc  = lps_pkg::CNT_W'(acc_sum);
    for (int k = 0; k < lps_pkg::LANES; k++)
      next_lane[k] = active && lps_pkg::lps_slot_bit(next_word, k, next_slot);
    next_fclk = active && (next_slot < lps_pkg::CLK_HIGH_SLOTS);
    // Asleep, every lane is driven to ground, even lane four in narrow mode
    next_oe = '1;
    if (s_depth && (state != lps_pkg::LPS_SLEEP))
      next_oe[lps_pkg::DEPTH_LANE] = 1'b0;
    if (sys_rst)
    begin
      next_word = lps_pkg::WORD_RST;
      next_slot = 3'h0;
      next_acc  = lps_pkg::CNT_RST;
      next_lane = '0;
      next_fclk = 1'b0;
      next_oe   = '1;
    end
  end

  always_ff @(posedge clock)
  begin
    word                <= next_word;
    slot                <= next_slot;
    acc                 <= next_acc;
    serial_lane_out     <= next_lane;
    serial_lane_oe      <= next_oe;
    forwarded_clock_out <= next_fclk;
    pclk_prev           <= sys_rst ? 1'b0 : s_pclk;
    swing_high          <= sys_rst ? 1'b0 : s_swing;
    pll_enable          <= sys_rst ? 1'b0 : (state != lps_pkg::LPS_SLEEP);
    low_power           <= sys_rst ? 1'b1 : (state == lps_pkg::LPS_SLEEP || state == lps_pkg::LPS_IDLE);
    link_locked         <= sys_rst ? 1'b0 : active;
    capture_ready       <= sys_rst ? 1'b0 : fifo_in_ready;
    pixel_overrun       <= sys_rst ? 1'b0 : (push_valid && !fifo_in_ready);
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_sleep_grounds: assert property (
    (state == lps_pkg::LPS_SLEEP) |=> (serial_lane_out == '0) && (serial_lane_oe == '1) && !forwarded_clock_out)
    else $error("sleep must ground every lane");

  a_depth_float: assert property (
    (s_depth && state != lps_pkg::LPS_SLEEP) |=> !serial_lane_oe[lps_pkg::DEPTH_LANE])
    else $error("narrow mode must float lane four");

  a_depth_masked: assert property (
    (push_valid && s_depth) |-> (push_data[lps_pkg::PIX_BITS-1:lps_pkg::DEPTH_LO_BIT] == '0))
    else $error("lane four bits not ignored");

  a_rise_latch: assert property (
    (s_edge_sel && s_pclk && !pclk_prev && state != lps_pkg::LPS_SLEEP) |-> push_valid)
    else $error("rising edge did not capture");

  a_fall_latch: assert property (
    (!s_edge_sel && !s_pclk && pclk_prev && state != lps_pkg::LPS_SLEEP) |-> push_valid)
    else $error("falling edge did not capture");

  a_clock_high_start: assert property (
    (active && latch_evt) |=> forwarded_clock_out && (slot == 3'h0))
    else $error("forwarded clock not high at frame start");

  a_slot_bound: assert property (
    (slot == lps_pkg::LAST_SLOT && !latch_evt) |=> (slot == lps_pkg::LAST_SLOT))
    else $error("slot ran past the seventh");

  a_loss_idle: assert property (
    (clk_lost && s_awake && (state == lps_pkg::LPS_ACTIVE || state == lps_pkg::LPS_LOCKING))
    |=> (state == lps_pkg::LPS_IDLE))
    else $error("lost clock did not idle");

  a_unlocked_quiet: assert property (
    (state != lps_pkg::LPS_ACTIVE) |=> (serial_lane_out == '0) && !forwarded_clock_out)
    else $error("lanes moved before lock");

  a_word_load: assert property (
    (latch_evt && fifo_out_valid) |=> (word == $past(fifo_out_data)))
    else $error("buffered word not loaded at frame start");

  a_swing_follow: assert property (
    $changed(s_swing) |=> (swing_high == $past(s_swing)))
    else $error("swing select not followed");

endmodule

// ---- bench/lps_rx_model.sv ----
`timescale 1ns/1ps
module lps_rx_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Link from the block
  input  wire logic [3:0]  lane,
  input  wire logic        fclk,
  // Recovered frames
  output logic             rx_valid,
  output logic      [27:0] rx_word
);
  logic        fclk_d;
  logic        started;
  logic [3:0]  lane_d;
  logic [27:0] acc;

  // Slot borders are not visible on the wire, so only slots 0, 4 and 6 are recovered
  always_ff @(posedge clock)
  begin
    fclk_d   <= sys_rst ? 1'b0 : fclk;
    lane_d   <= lane;
    rx_valid <= 1'b0;
    if (sys_rst)
      started <= 1'b0;
    else if (fclk && !fclk_d)
    begin
      started  <= 1'b1;
      rx_valid <= started;
      rx_word  <= acc;
      for (int k = 0; k < 4; k++)
      begin
        rx_word[7*k] <= lane_d[k];
        acc[7*k+6]   <= lane[k];
      end
    end
    else if (!fclk && fclk_d)
      for (int k = 0; k < 4; k++)
        acc[7*k+2] <= lane[k];
  end
endmodule

// ---- bench/test_lps_serializer.sv ----
`timescale 1ns/1ps
module test_lps_serializer;
  // ****************************************************************
  // Pins and bench state
  // ****************************************************************
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        pixel_clock = 1'b0;
  logic [27:0] pixel_data = 28'h0000000;
  logic        latch_edge_select = 1'b1;
  logic        sleep_control_n = 1'b0;
  logic        swing_select = 1'b0;
  logic        color_depth_select = 1'b0;
  logic [3:0]  serial_lane_out;
  logic [3:0]  serial_lane_oe;
  logic        forwarded_clock_out;
  logic        swing_high;
  logic        pll_enable;
  logic        low_power;
  logic        link_locked;
  logic        capture_ready;
  logic        pixel_overrun;
  logic [3:0]  lane_wire;
  logic        float_pat = 1'b0;
  logic        pix_run = 1'b0;
  logic [1:0]  pix_cnt = 2'h0;
  int          n_rise = 0;
  logic        rx_valid;
  logic [27:0] rx_word;
  logic [27:0] word_q[$];
  logic [27:0] rxq[$];
  int          miscompares = 0;
  int          samples_checked = 0;

  always #12.5 clock = ~clock;

  // A floating lane shows a toggling level so a stale value never passes
  assign lane_wire = (serial_lane_out & serial_lane_oe) | ({4{float_pat}} & ~serial_lane_oe);

  lps_serializer #(.FIFO_WORDS(lps_pkg::FIFO_DEPTH)) i_lps_serializer (
    .clock(clock), .sys_rst(sys_rst), .pixel_clock(pixel_clock), .pixel_data(pixel_data),
    .latch_edge_select(latch_edge_select), .sleep_control_n(sleep_control_n),
    .swing_select(swing_select), .color_depth_select(color_depth_select),
    .serial_lane_out(serial_lane_out), .serial_lane_oe(serial_lane_oe),
    .forwarded_clock_out(forwarded_clock_out), .swing_high(swing_high), .pll_enable(pll_enable),
    .low_power(low_power), .link_locked(link_locked), .capture_ready(capture_ready),
    .pixel_overrun(pixel_overrun));
  lps_rx_model i_lps_rx_model (.clock(clock), .sys_rst(sys_rst), .lane(lane_wire),
    .fclk(forwarded_clock_out), .rx_valid(rx_valid), .rx_word(rx_word));

  // ****************************************************************
  // Pixel source, 200 ns period
  // ****************************************************************
  // Data is valid only just after the latching edge, so the wrong edge reads the inverse
  // Rate is scaled down to suit the sampling clock, so the real pixel rate range is not reached
  always @(posedge clock)
  begin
    #2;
    float_pat = ~float_pat;
    if (pix_run)
    begin
      pix_cnt = pix_cnt + 2'h1;
      if (pix_cnt == 2'h0)
      begin
        pixel_clock = ~pixel_clock;
        if (pixel_clock == latch_edge_select)
        begin
          n_rise = n_rise + 1;
          pixel_data = (word_q.size() > 0) ? word_q.pop_front() : 28'h0000000;
        end
      end
      else if (pix_cnt == 2'h2 && pixel_clock == latch_edge_select)
        pixel_data = ~pixel_data;
    end
  end

  always @(posedge clock)
    if (rx_valid === 1'b1)
      rxq.push_back(rx_word);

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic report_and_stop;
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [27:0] got, input logic [27:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(inout int n, input int lim);
    @(posedge clock);
    #2;
    n++;
    if (n > lim)
    begin
      check(28'h0000000, 28'h0000001, "wait expired");
      report_and_stop;
    end
  endtask

  task automatic wait_lock;
    int n;
    n = 0;
    n_rise = 0;
    while (link_locked !== 1'b1)
    begin
      if (serial_lane_out !== 4'h0 || forwarded_clock_out !== 1'b0)
        check(28'({forwarded_clock_out, serial_lane_out}), 28'h0000000, "lanes before lock");
      tick(n, 200);
    end
    check(28'(n_rise >= 5), 28'h0000001, "lock edge count");
    check(28'(low_power), 28'h0000000, "low power while locked");
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_wake;
    int n;
    n = 0;
    check(28'({low_power, pll_enable, link_locked, forwarded_clock_out, capture_ready,
               pixel_overrun, serial_lane_oe, serial_lane_out}), 28'h00020F0, "reset state");
    sleep_control_n = 1'b1;
    while (pll_enable !== 1'b1)
      tick(n, 6);
    check(28'(low_power), 28'h0000001, "idle without clock");
    pix_run = 1'b1;
    wait_lock;
  endtask

  task automatic t_stream(input logic les, input logic depth);
    logic [27:0] w[6];
    logic [27:0] mask;
    int n;
    int hi;
    int j0;
    n = 0;
    hi = 0;
    j0 = -1;
    latch_edge_select = les;
    color_depth_select = depth;
    while (n < 24)
      tick(n, 24);
    rxq.delete();
    for (int i = 0; i < 28; i++)
      mask[i] = (i % 7 == 0 || i % 7 == 2 || i % 7 == 6) && !(depth && i >= 21);
    for (int i = 0; i < 6; i++)
    begin
      w[i] = 28'(32'h09E3779B * (i + 1));
      word_q.push_back(w[i]);
    end
    n = 0;
    while (n < 96)
    begin
      hi += int'(forwarded_clock_out);
      tick(n, 96);
    end
    check(28'(hi >= 48 && hi <= 60), 28'h0000001, "clock duty");
    check(28'(rxq.size() >= 11 && rxq.size() <= 12), 28'h0000001, "frame count");
    check(28'(serial_lane_oe), depth ? 28'h0000007 : 28'h000000F, "lane enables");
    foreach (rxq[j])
      if (j0 < 0 && (rxq[j] & mask) === (w[0] & mask))
        j0 = j;
    check(28'(j0 >= 0 && j0 + 6 <= rxq.size()), 28'h0000001, "first frame");
    if (j0 >= 0 && j0 + 6 <= rxq.size())
      for (int i = 1; i < 6; i++)
        check(rxq[j0 + i] & mask, w[i] & mask, "frame word");
  endtask

  task automatic t_swing;
    int n;
    for (int v = 1; v >= 0; v--)
    begin
      n = 0;
      swing_select = v[0];
      while (swing_high !== v[0])
        tick(n, 4);
      check(28'(swing_high), 28'(v), "swing");
    end
  endtask

  task automatic t_stop;
    int n;
    n = 0;
    pix_run = 1'b0;
    while (link_locked !== 1'b0)
      tick(n, 100);
    check(28'(n >= 72), 28'h0000001, "clock loss too early");
    check(28'({low_power, serial_lane_out, forwarded_clock_out}), 28'h0000020, "idle outputs");
    pix_run = 1'b1;
    wait_lock;
  endtask

  task automatic t_sleep;
    int n;
    n = 0;
    for (int i = 0; i < 4; i++)
      word_q.push_back(28'h0000000);
    while (word_q.size() > 0)
      tick(n, 100);
    n = 0;
    sleep_control_n = 1'b0;
    while (pll_enable !== 1'b0)
      tick(n, 6);
    tick(n, 8);
    check(28'({serial_lane_oe, serial_lane_out, forwarded_clock_out, link_locked, low_power}),
          28'h0000781, "sleep outputs");
    check(28'(capture_ready), 28'h0000001, "buffer after sleep");
    pix_run = 1'b0;
  endtask

  // Push and pop share the latching edge, so steady streaming never fills the buffer
  task automatic t_buffer;
    int n;
    n = 0;
    while (n < 40)
    begin
      check(28'(capture_ready), 28'h0000001, "buffer ready");
      check(28'(pixel_overrun), 28'h0000000, "capture dropped");
      tick(n, 40);
    end
  endtask

  initial
  begin
    repeat (5) @(posedge clock);
    #2;
    sys_rst = 1'b0;
    t_wake;
    t_stream(1'b1, 1'b0);
    t_stream(1'b0, 1'b0);
    t_stream(1'b1, 1'b1);
    t_swing;
    t_stop;
    t_buffer;
    t_sleep;
    report_and_stop;
  end
endmodule
